// *** rtl/fwsr_pkg.sv ***
// package with constants and types for the flash status polling controller
package fwsr_pkg;
  // ===========================================================================
  // register map of the controller's own APB registers
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_ADDR    = 8'h04;
  localparam logic [7:0] ADDR_DATA    = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_RDDATA  = 8'h10;
  // control register fields
  localparam int CTRL_GO       = 0;
  localparam int CTRL_MODE_LO  = 1;
  localparam int CTRL_MODE_HI  = 2;
  localparam int CTRL_USE_TGL  = 3;
  // status register fields
  localparam int ST_BUSY       = 0;
  localparam int ST_DONE       = 1;
  localparam int ST_FAIL       = 2;
  localparam int ST_RB         = 3;
  // ===========================================================================
  // flash bus widths and bit positions
  localparam int FA_W          = 21;
  localparam int FD_W          = 8;
  localparam int BIT_POLL      = 7;
  localparam int BIT_TGL1      = 6;
  localparam int BIT_FAIL      = 5;
  localparam int BIT_TGL2      = 2;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  // ===========================================================================
  // timing: bus cycle phase length in clk cycles (70 ns access at 40 ns clock)
  localparam int CLK_NS        = 40;
  localparam int ACCESS_NS     = 70;
  localparam int ACCESS_CYC    = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC      = 2;
  localparam int CNT_W         = 4;
  // ===========================================================================
  // operation modes
  typedef enum logic [1:0] {
    FWSR_OP_WRITE,
    FWSR_OP_READ,
    FWSR_OP_POLL_PROG,
    FWSR_OP_POLL_ERASE
  } fwsr_op_t;
  // bus cycle engine commands
  typedef enum logic [1:0] {
    FWSR_BC_NONE,
    FWSR_BC_RD,
    FWSR_BC_WR
  } fwsr_bc_t;
endpackage

// *** rtl/fwsr_bus_cycle.sv ***
// one asynchronous read or write cycle on the flash parallel pins
`timescale 1ns/1ns
module fwsr_bus_cycle (
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire fwsr_pkg::fwsr_bc_t        cmd,
  input  wire logic [fwsr_pkg::FA_W-1:0] addr,
  input  wire logic [fwsr_pkg::FD_W-1:0] wdata,
  output logic                           done,
  output logic [fwsr_pkg::FD_W-1:0]      rdata,
  output logic [fwsr_pkg::FA_W-1:0]      flash_addr,
  output logic [fwsr_pkg::FD_W-1:0]      flash_dq_out,
  output logic                           flash_dq_oe,
  input  wire logic [fwsr_pkg::FD_W-1:0] flash_dq_in,
  output logic                           chip_select_n,
  output logic                           output_strobe_n,
  output logic                           write_strobe_n
);
  typedef enum logic [1:0] {FWSR_BC_IDLE, FWSR_BC_ACT, FWSR_BC_GAP} fwsr_bcst_t;
  typedef struct packed {
    fwsr_bcst_t                 st;
    logic [fwsr_pkg::CNT_W-1:0] cnt;
    logic                       is_wr;
    logic                       done;
    logic [fwsr_pkg::FD_W-1:0]  rdata;
    logic [fwsr_pkg::FA_W-1:0]  addr;
    logic [fwsr_pkg::FD_W-1:0]  wdata;
    logic                       cs_n;
    logic                       oe_n;
    logic                       we_n;
    logic [fwsr_pkg::FD_W-1:0]  s1;
    logic [fwsr_pkg::FD_W-1:0]  s2;
  } fwsr_bc_state_t;
  fwsr_bc_state_t r;
  fwsr_bc_state_t next_r;

  // ===========================================================================
  // strobe sequencing; each read strobe is a fresh read cycle for the toggle bits
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.s1 = flash_dq_in;
    next_r.s2 = r.s1;
    unique case (r.st)
      FWSR_BC_IDLE: begin
        if (cmd != fwsr_pkg::FWSR_BC_NONE) begin
          next_r.st = FWSR_BC_ACT;
          next_r.is_wr = (cmd == fwsr_pkg::FWSR_BC_WR);
          next_r.addr = addr;
          next_r.wdata = wdata;
          next_r.cs_n = 1'b0;
          next_r.oe_n = (cmd == fwsr_pkg::FWSR_BC_WR);
          next_r.we_n = (cmd != fwsr_pkg::FWSR_BC_WR);
          next_r.cnt = '0;
        end
      end
      FWSR_BC_ACT: begin
        // two extra cycles cover the input synchroniser
        if (r.cnt == fwsr_pkg::CNT_W'(fwsr_pkg::ACCESS_CYC + fwsr_pkg::SYNC_CYC)) begin
          next_r.st = FWSR_BC_GAP;
          next_r.cs_n = 1'b1;
          next_r.oe_n = 1'b1;
          next_r.we_n = 1'b1; // write data latched at this rising edge
          next_r.rdata = r.s2;
          next_r.cnt = '0;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      FWSR_BC_GAP: begin
        if (r.cnt == fwsr_pkg::CNT_W'(fwsr_pkg::ACCESS_CYC)) begin
          next_r.st = FWSR_BC_IDLE;
          next_r.done = 1'b1;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      default: next_r.st = FWSR_BC_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{st: FWSR_BC_IDLE, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign done            = r.done;
  assign rdata           = r.rdata;
  assign flash_addr      = r.addr;
  assign flash_dq_out    = r.wdata;
  assign flash_dq_oe     = r.is_wr && (r.st != FWSR_BC_IDLE);
  assign chip_select_n   = r.cs_n;
  assign output_strobe_n = r.oe_n;
  assign write_strobe_n  = r.we_n;
endmodule

// *** rtl/fwsr_ctrl.sv ***
// apb controlled host that programs, erases and polls write status of a parallel flash
`timescale 1ns/1ns
module fwsr_ctrl (
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic [fwsr_pkg::FA_W-1:0]      flash_addr,
  output logic [fwsr_pkg::FD_W-1:0]      flash_dq_out,
  output logic                           flash_dq_oe,
  input  wire logic [fwsr_pkg::FD_W-1:0] flash_dq_in,
  output logic                           chip_select_n,
  output logic                           output_strobe_n,
  output logic                           write_strobe_n,
  input  wire logic                      ready_busy_n_pin
);
  typedef enum logic [2:0] {
    FWSR_IDLE, FWSR_ISSUE, FWSR_WAIT, FWSR_EVAL, FWSR_ABORT, FWSR_RESET, FWSR_FINISH
  } fwsr_st_t;
  typedef struct packed {
    fwsr_st_t                   st;
    fwsr_pkg::fwsr_op_t         op;
    logic                       use_tgl;
    logic [fwsr_pkg::FA_W-1:0]  addr;
    logic [fwsr_pkg::FD_W-1:0]  data;
    logic [fwsr_pkg::FD_W-1:0]  rddata;
    logic [fwsr_pkg::FD_W-1:0]  prev;
    logic                       have_prev;
    logic                       true_seen;
    logic                       fail_seen;
    logic                       busy;
    logic                       done;
    logic                       fail;
    logic                       rb1;
    logic                       rb2;
    logic [31:0]                prdata;
  } fwsr_state_t;
  fwsr_state_t r;
  fwsr_state_t next_r;

  fwsr_pkg::fwsr_bc_t        bc_cmd;
  logic                      bc_done;
  logic [fwsr_pkg::FD_W-1:0] bc_rdata;
  logic                      apb_wr;
  logic                      apb_rd;
  logic                      mapped;
  logic [fwsr_pkg::FD_W-1:0] exp;
  logic                      poll_true;
  logic                      tgl_same;

  // ===========================================================================
  // pin level bus cycles
  fwsr_bus_cycle u_bus (
    .clk             (clk),
    .arst_n          (arst_n),
    .cmd             (bc_cmd),
    .addr            (r.addr),
    .wdata           ((r.st == FWSR_ABORT) ? fwsr_pkg::CMD_RESET : r.data),
    .done            (bc_done),
    .rdata           (bc_rdata),
    .flash_addr      (flash_addr),
    .flash_dq_out    (flash_dq_out),
    .flash_dq_oe     (flash_dq_oe),
    .flash_dq_in     (flash_dq_in),
    .chip_select_n   (chip_select_n),
    .output_strobe_n (output_strobe_n),
    .write_strobe_n  (write_strobe_n)
  );

  // ===========================================================================
  // apb decode; slave answers with zero wait states
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && !penable && !pwrite;
  assign mapped  = (paddr == fwsr_pkg::ADDR_CTRL) || (paddr == fwsr_pkg::ADDR_ADDR) ||
                   (paddr == fwsr_pkg::ADDR_DATA) || (paddr == fwsr_pkg::ADDR_STATUS) ||
                   (paddr == fwsr_pkg::ADDR_RDDATA);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = r.prdata;

  // poll evaluation helpers
  assign exp       = (r.op == fwsr_pkg::FWSR_OP_POLL_ERASE) ? {fwsr_pkg::FD_W{1'b1}} : r.data;
  assign poll_true = (bc_rdata[fwsr_pkg::BIT_POLL] == exp[fwsr_pkg::BIT_POLL]);
  assign tgl_same  = (bc_rdata[fwsr_pkg::BIT_TGL1] == r.prev[fwsr_pkg::BIT_TGL1]);

  // bus cycle request for one cycle only, so a finished cycle is never restarted
  always_comb begin
    bc_cmd = fwsr_pkg::FWSR_BC_NONE;
    if (r.st == FWSR_ISSUE) begin
      bc_cmd = (r.op == fwsr_pkg::FWSR_OP_WRITE) ? fwsr_pkg::FWSR_BC_WR : fwsr_pkg::FWSR_BC_RD;
    end else if (r.st == FWSR_ABORT) begin
      bc_cmd = fwsr_pkg::FWSR_BC_WR;
    end
  end

  // ===========================================================================
  // sequencer and register file
  always_comb begin
    next_r = r;
    next_r.rb1 = ready_busy_n_pin;
    next_r.rb2 = r.rb1;
    next_r.prdata = '0;
    if (apb_rd) begin
      unique case (paddr)
        fwsr_pkg::ADDR_CTRL:   next_r.prdata = {28'h0, r.use_tgl, r.op, 1'b0};
        fwsr_pkg::ADDR_ADDR:   next_r.prdata = {11'h0, r.addr};
        fwsr_pkg::ADDR_DATA:   next_r.prdata = {24'h0, r.data};
        fwsr_pkg::ADDR_STATUS: next_r.prdata = {28'h0, r.rb2, r.fail, r.done, r.busy};
        fwsr_pkg::ADDR_RDDATA: next_r.prdata = {24'h0, r.rddata};
        default:               next_r.prdata = '0;
      endcase
    end
    if (apb_wr && !r.busy) begin
      unique case (paddr)
        fwsr_pkg::ADDR_ADDR: next_r.addr = pwdata[fwsr_pkg::FA_W-1:0];
        fwsr_pkg::ADDR_DATA: next_r.data = pwdata[fwsr_pkg::FD_W-1:0];
        fwsr_pkg::ADDR_CTRL: begin
          next_r.op      = fwsr_pkg::fwsr_op_t'(pwdata[fwsr_pkg::CTRL_MODE_HI:fwsr_pkg::CTRL_MODE_LO]);
          next_r.use_tgl = pwdata[fwsr_pkg::CTRL_USE_TGL];
          if (pwdata[fwsr_pkg::CTRL_GO]) begin
            // a new start always begins polling from its first step
            next_r.st        = FWSR_ISSUE;
            next_r.busy      = 1'b1;
            next_r.done      = 1'b0;
            next_r.fail      = 1'b0;
            next_r.have_prev = 1'b0;
            next_r.true_seen = 1'b0;
            next_r.fail_seen = 1'b0;
          end
        end
        default: ;
      endcase
    end
    unique case (r.st)
      FWSR_IDLE:   ;
      FWSR_ISSUE:  next_r.st = FWSR_WAIT;
      FWSR_WAIT: begin
        if (bc_done) begin
          next_r.st = (r.op == fwsr_pkg::FWSR_OP_WRITE) ? FWSR_FINISH : FWSR_EVAL;
        end
      end
      FWSR_EVAL: begin
        next_r.rddata    = bc_rdata;
        next_r.prev      = bc_rdata;
        next_r.have_prev = 1'b1;
        next_r.st        = FWSR_ISSUE;
        if (r.op == fwsr_pkg::FWSR_OP_READ) begin
          next_r.st = FWSR_FINISH;
        end else if (r.true_seen) begin
          next_r.st = FWSR_FINISH;
        end else if (!r.use_tgl) begin
          // poll bit at the target address; the same address serves
          if (poll_true) begin
            next_r.true_seen = 1'b1;
          end else if (r.fail_seen) begin
            next_r.fail = 1'b1;
            next_r.st   = FWSR_ABORT;
          end else if (bc_rdata[fwsr_pkg::BIT_FAIL]) begin
            next_r.fail_seen = 1'b1;
          end
        end else if (r.have_prev) begin
          if (tgl_same) begin
            next_r.true_seen = 1'b1;
          end else if (r.fail_seen) begin
            next_r.fail = 1'b1;
            next_r.st   = FWSR_ABORT;
          end else if (bc_rdata[fwsr_pkg::BIT_FAIL]) begin
            next_r.fail_seen = 1'b1;
          end
        end
      end
      FWSR_ABORT:  next_r.st = FWSR_RESET;
      FWSR_RESET: begin
        if (bc_done) begin
          next_r.st = FWSR_FINISH;
        end
      end
      FWSR_FINISH: begin
        next_r.st   = FWSR_IDLE;
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end
      default: next_r.st = FWSR_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{st: FWSR_IDLE, op: fwsr_pkg::FWSR_OP_WRITE, rb1: 1'b1, rb2: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end
endmodule

// *** sim/fwsr_ctrl_properties.sv ***
// port assertions for the flash status polling controller
`timescale 1ns/1ns
module fwsr_props (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [20:0] flash_addr,
  input wire logic [7:0]  flash_dq_out,
  input wire logic        flash_dq_oe,
  input wire logic        chip_select_n,
  input wire logic        output_strobe_n,
  input wire logic        write_strobe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [20:0] addr_q;
  // shadow of the flash address register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) addr_q <= 21'h0;
    else if (psel && penable && pwrite && paddr == fwsr_pkg::ADDR_ADDR) addr_q <= pwdata[20:0];
  end
  // ==========
  // assertions
  property p_ready; psel |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("apb wait state");
  property p_slverr; psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}); endproperty
  a_slverr: assert property (p_slverr) else $error("bad slave error");
  property p_rd_zero; psel && penable && !pwrite && pslverr |-> prdata == 32'h0; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
  property p_cycle; $fell(chip_select_n) |-> !chip_select_n [*5] ##1 chip_select_n [*3]; endproperty
  a_cycle: assert property (p_cycle) else $error("flash cycle length");
  property p_framed; !output_strobe_n || !write_strobe_n |-> !chip_select_n; endproperty
  a_framed: assert property (p_framed) else $error("strobe outside select");
  property p_no_fight; !output_strobe_n |-> !flash_dq_oe && write_strobe_n; endproperty
  a_no_fight: assert property (p_no_fight) else $error("host drives during read");
  property p_wr_data; !write_strobe_n && !$past(write_strobe_n) |-> flash_dq_oe && $stable(flash_dq_out); endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data moved");
  property p_addr_hold; !chip_select_n && !$past(chip_select_n) |-> $stable(flash_addr); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_addr_src; $fell(chip_select_n) |-> flash_addr == addr_q; endproperty
  a_addr_src: assert property (p_addr_src) else $error("cycle at wrong address");
endmodule
bind fwsr_ctrl fwsr_props u_props (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .flash_addr, .flash_dq_out, .flash_dq_oe, .chip_select_n, .output_strobe_n, .write_strobe_n);

// *** sim/fwsr_flash_model.sv ***
// behavioural flash device giving write status on its data pins
`timescale 1ns/1ns
module fwsr_flash_model #(
  parameter int BUSY_READS = 6,
  parameter int FAIL_READS = 4
) (
  input  wire logic [20:0] flash_addr,
  input  wire logic [7:0]  flash_dq_out,
  input  wire logic        chip_select_n,
  input  wire logic        output_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic        fail_en,
  input  wire logic        prot_en,
  output logic [7:0]       flash_dq_in,
  output logic             busy_drive
);
  typedef enum logic [1:0] {FWSR_IDLE, FWSR_PROG, FWSR_ERASE, FWSR_SUSP} fwsr_mode_t;
  fwsr_mode_t mode = FWSR_IDLE;
  logic [7:0] mem [16], pd, wd, val, last = 8'h00;
  logic [3:0] pa, al;
  logic       sec, arm = 0, t1 = 0, t2 = 0, fail = 0, sus = 0;
  int         cnt = 0;
  wire        rd = !chip_select_n && !output_strobe_n;
  wire        wr = !chip_select_n && !write_strobe_n;
  wire        in_sec = al[3] == sec;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // address and data held from the active cycle
  always @* if (rd || wr) al = flash_addr[3:0];
  always @* if (wr) wd = flash_dq_out;
  // commands act at the end of the write pulse
  always @(negedge wr) begin
    if (wd == 8'hF0) begin
      mode <= FWSR_IDLE;
      arm <= 0;
      fail <= 0;
      sus <= 0;
    end else if (arm) begin
      pa <= al;
      pd <= wd;
      sus <= mode == FWSR_SUSP;
      mode <= FWSR_PROG;
      cnt <= 0;
      arm <= 0;
    end else if (wd == 8'hA0) arm <= 1;
    else if (wd == 8'hB0 && mode == FWSR_ERASE) mode <= FWSR_SUSP;
    else if (wd == 8'h30 && mode == FWSR_SUSP) begin
      mode <= FWSR_ERASE;
      cnt <= 0;
    end
    else if (wd == 8'h30) begin
      sec <= al[3];
      mode <= FWSR_ERASE;
      cnt <= 0;
    end
  end
  // every finished read during a program or erase advances the algorithm and toggle bit t1; t2 toggles on in-sector reads in erase and suspend
  always @(negedge rd) begin
    last <= val;
    if (mode == FWSR_ERASE || mode == FWSR_SUSP) t2 <= t2 ^ in_sec;
    if (mode == FWSR_PROG || mode == FWSR_ERASE) begin
      t1 <= !t1;
      cnt <= cnt + 1;
      if (fail_en && cnt + 1 >= FAIL_READS) fail <= 1;
      if (!fail_en && cnt + 1 >= BUSY_READS) begin
        // a program inside erase suspend returns to the suspended erase
        mode <= sus ? FWSR_SUSP : FWSR_IDLE;
        sus <= 0;
        // sector 1 is protected while prot_en is high; it keeps its contents
        if (mode == FWSR_PROG && !(prot_en && pa[3])) mem[pa] <= mem[pa] & pd;
        else if (mode == FWSR_ERASE && !(prot_en && sec))
          foreach (mem[i]) if (i[3] == sec) mem[i] <= 8'hFF;
      end
    end
  end
  // status byte or array data; released lines show the inverse of the last byte
  always @* begin
    case (mode)
      FWSR_PROG:  val = {~pd[7], t1, fail, 5'h00};
      FWSR_ERASE: val = {1'b0, t1, fail, 2'h1, t2 & in_sec, 2'h0};
      FWSR_SUSP:  val = in_sec ? {1'b1, t1, 3'h0, t2, 2'h0} : mem[al];
      default:    val = mem[al];
    endcase
  end
  assign flash_dq_in = rd ? val : ~last;
  assign busy_drive = mode == FWSR_PROG || mode == FWSR_ERASE;
endmodule

// *** sim/tb.sv ***
// self-checking bench of the flash status polling controller
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic [1:0]         prep;
    fwsr_pkg::fwsr_op_t op;
    logic               tgl;
    logic [20:0]        addr;
    logic [7:0]         data;
    logic [7:0]         exp;
  } fwsr_row_t;
  logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, fail_en = 0, prot_en = 0, e;
  logic [7:0]  paddr = 8'h00, flash_dq_out, flash_dq_in;
  logic [31:0] pwdata = 32'h0, prdata, r, b;
  logic [20:0] flash_addr;
  logic        pready, pslverr, flash_dq_oe, chip_select_n, output_strobe_n, write_strobe_n, busy_drive;
  wire         ready_busy_n_pin = !busy_drive; // pull-up unless the device pulls low
  int          miscompares = 0, n_compared = 0;
  logic [7:0]  cmd [6] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55, 8'h30};
  logic [20:0] adr [6] = '{21'hAAA, 21'h555, 21'hAAA, 21'hAAA, 21'h555, 21'h0};
  fwsr_row_t   rows [7] = '{
    '{1, fwsr_pkg::FWSR_OP_POLL_PROG, 0, 21'h9, 8'h5A, 8'h5A},
    '{1, fwsr_pkg::FWSR_OP_POLL_PROG, 1, 21'h2, 8'hA5, 8'hA5},
    '{0, fwsr_pkg::FWSR_OP_READ, 0, 21'h9, 8'h00, 8'h5A},
    '{2, fwsr_pkg::FWSR_OP_POLL_ERASE, 0, 21'h8, 8'h00, 8'hFF},
    '{0, fwsr_pkg::FWSR_OP_READ, 0, 21'h9, 8'h00, 8'hFF},
    '{0, fwsr_pkg::FWSR_OP_READ, 0, 21'h2, 8'h00, 8'hA5},
    '{2, fwsr_pkg::FWSR_OP_POLL_ERASE, 1, 21'hA, 8'h00, 8'hFF}};
  fwsr_ctrl dut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .flash_addr,
    .flash_dq_out, .flash_dq_oe, .flash_dq_in, .chip_select_n, .output_strobe_n, .write_strobe_n, .ready_busy_n_pin);
  fwsr_flash_model flash (.flash_addr, .flash_dq_out, .chip_select_n, .output_strobe_n, .write_strobe_n, .fail_en,
    .prot_en, .flash_dq_in, .busy_drive);
  // ==========
  // clock and helpers
  initial forever #20 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic run_op(input fwsr_pkg::fwsr_op_t op, input logic t, input logic [20:0] a, input logic [7:0] d);
    apb(1, fwsr_pkg::ADDR_ADDR, {11'h0, a});
    apb(1, fwsr_pkg::ADDR_DATA, {24'h0, d});
    apb(1, fwsr_pkg::ADDR_CTRL, {28'h0, t, op, 1'b1});
    repeat (2) @(posedge clk);
    do apb(0, fwsr_pkg::ADDR_STATUS, 0); while (r[fwsr_pkg::ST_BUSY] !== 1'b0);
    repeat (4) @(posedge clk);
  endtask
  // command sequence: 1 program, 2 sector erase
  task automatic seq(input logic [1:0] k, input logic [20:0] a, input logic [7:0] d);
    for (int i = 0; i < 6; i++)
      if (k == 2 || (k == 1 && i < 3))
        run_op(fwsr_pkg::FWSR_OP_WRITE, 0, i == 5 ? a : adr[i], k == 1 && i == 2 ? 8'hA0 : cmd[i]);
    if (k == 1) run_op(fwsr_pkg::FWSR_OP_WRITE, 0, a, d);
  endtask
  task automatic test_done;
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========
  // tests
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1;
    apb(0, fwsr_pkg::ADDR_STATUS, 0);
    chk(r[3:0], 4'h8);
    apb(0, 8'h14, 0);
    chk(e, 1);
    chk(r, 0);
    // register readback: address, data byte, control fields with go reading zero
    apb(1, fwsr_pkg::ADDR_ADDR, 32'h001FFFFF);
    apb(0, fwsr_pkg::ADDR_ADDR, 0);
    chk(r, 32'h001FFFFF);
    apb(1, fwsr_pkg::ADDR_DATA, 32'h000001C3);
    apb(0, fwsr_pkg::ADDR_DATA, 0);
    chk(r, 32'h000000C3);
    apb(1, fwsr_pkg::ADDR_CTRL, 32'h0000000A);
    apb(0, fwsr_pkg::ADDR_CTRL, 0);
    chk(r, 32'h0000000A);
    foreach (rows[i]) begin
      seq(rows[i].prep, rows[i].addr, rows[i].data);
      run_op(rows[i].op, rows[i].tgl, rows[i].addr, rows[i].data);
      apb(0, fwsr_pkg::ADDR_RDDATA, 0);
      chk(r[7:0], rows[i].exp);
      apb(0, fwsr_pkg::ADDR_STATUS, 0);
      chk(r[3:0], 4'hA);
    end
    fail_en <= 1;
    seq(1, 21'hC, 8'h3C);
    run_op(fwsr_pkg::FWSR_OP_POLL_PROG, 0, 21'hC, 8'h3C);
    apb(0, fwsr_pkg::ADDR_STATUS, 0);
    chk(r[3:0], 4'hE);
    fail_en <= 0;
    run_op(fwsr_pkg::FWSR_OP_READ, 0, 21'hC, 8'h00);
    apb(0, fwsr_pkg::ADDR_RDDATA, 0);
    chk(r[7:0], 8'hFF);
    // program into a protected sector: busy for a while, then the old byte
    prot_en <= 1;
    seq(1, 21'hA, 8'h00);
    run_op(fwsr_pkg::FWSR_OP_POLL_PROG, 1, 21'hA, 8'h00);
    prot_en <= 0;
    apb(0, fwsr_pkg::ADDR_RDDATA, 0);
    chk(r[7:0], 8'hFF);
    apb(0, fwsr_pkg::ADDR_STATUS, 0);
    chk(r[3:0], 4'hA);
    seq(2, 21'h0, 8'h00);
    apb(0, fwsr_pkg::ADDR_STATUS, 0);
    chk(r[3], 0);
    run_op(fwsr_pkg::FWSR_OP_WRITE, 0, 21'h0, 8'hB0);
    run_op(fwsr_pkg::FWSR_OP_READ, 0, 21'h2, 8'h00);
    apb(0, fwsr_pkg::ADDR_RDDATA, 0);
    b = r;
    run_op(fwsr_pkg::FWSR_OP_READ, 0, 21'h2, 8'h00);
    apb(0, fwsr_pkg::ADDR_RDDATA, 0);
    chk(b[7], 1);
    chk(b ^ r, 32'h4);
    apb(0, fwsr_pkg::ADDR_STATUS, 0);
    chk(r[3], 1);
    // program outside the suspended sector, then back in suspend
    seq(1, 21'h9, 8'h11);
    run_op(fwsr_pkg::FWSR_OP_POLL_PROG, 0, 21'h9, 8'h11);
    apb(0, fwsr_pkg::ADDR_RDDATA, 0);
    chk(r[7:0], 8'h11);
    apb(0, fwsr_pkg::ADDR_STATUS, 0);
    chk(r[3:0], 4'hA);
    run_op(fwsr_pkg::FWSR_OP_WRITE, 0, 21'h0, 8'h30);
    run_op(fwsr_pkg::FWSR_OP_POLL_ERASE, 0, 21'h2, 8'h00);
    apb(0, fwsr_pkg::ADDR_RDDATA, 0);
    chk(r[7:0], 8'hFF);
    // reset in the middle of a read cycle
    apb(1, fwsr_pkg::ADDR_CTRL, 32'h00000003);
    repeat (3) @(posedge clk);
    arst_n <= 0;
    @(posedge clk);
    chk({chip_select_n, output_strobe_n, write_strobe_n, flash_dq_oe}, 4'hE);
    arst_n <= 1;
    apb(0, fwsr_pkg::ADDR_STATUS, 0);
    chk(r[3:0], 4'h8);
    test_done;
  end
  // watchdog against a hung wait
  initial begin
    repeat (50000) @(posedge clk);
    miscompares++;
    test_done;
  end
endmodule
